// >>> design/incremental_encoder_frontend.sv
// Encoder front end: glitch filters, edge evaluation, zero-pulse reaction.
// Assumes an external counter core that consumes the count and load
// strobes and returns its value on counter_value. Inputs are synchronous.
//
// How it works
// R01: Single mode counts A edges only while B is low.
// R02: Double mode counts every A edge, B level ignored.
// R03: Quadruple mode counts every edge of A and B.
// R04: Evaluation mode applies only to the two phase-shifted encoder types.
// R05: A, B and N each pass through their own glitch filter.
// R06: Level changes shorter than the minimum pulse time are discarded.
// R07: Minimum time comes from the chosen filter step, 100 Hz to 1 MHz.
// R08: Encoder keeps duty between about 40:60 and 60:40.
// R09: With no N reaction, N never touches the counter.
// R10: Sync reaction loads the start value on N.
// R11: A gating input, when assigned, must be active for N sync.
// R12: Capture reaction copies the counter value on N.
// R13: N capture and input capture work side by side.
// R14: N reaction only acts with the A, B, N signal type.
// R15: N capture only when count value is the reference.
// R16: One frequency setting covers N sync and input sync.
// R17: Once sync loads only at the first N or input edge.
// R18: Periodic sync loads at every N or input edge.
// R19: Once capture stores only at the first trigger.
// R20: Periodic capture stores at every trigger.
// R21: Push-pull encoder lines are watched for wire break.
// R22: A leading B counts up, B leading A counts down.
// R23: Invert setting reverses the derived direction.
`timescale 1ns/1ps
`default_nettype none

module incremental_encoder_frontend
  import enc_frontend_pkg::*;
#(
  parameter filt_cnt_t FILT_CYC [N_FILT] = FILT_CYC_DEF
) (
  input wire logic pclk, // Bus and system clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte enables
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic enc_a, // Encoder A
  input wire logic enc_b, // Encoder B
  input wire logic enc_n, // Encoder zero pulse
  input wire logic [2:0] wb_fault, // Line receiver fault per A, B, N
  input wire logic di_sync, // Input for sync edges
  input wire logic di_gate, // Input enabling N sync, high active
  input wire logic di_capture, // Input for capture edges
  input wire logic [31:0] counter_value, // Value of the counter core
  output logic cnt_up, // Count up pulse
  output logic cnt_down, // Count down pulse
  output logic sync_load, // Load start value pulse
  output logic [31:0] start_value, // Start value for the core
  output logic cap_strobe, // Capture happened pulse
  output logic [31:0] capture_value, // Captured counter value
  output logic wire_break // Wire break seen, level
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic addr_ok(input logic [7:0] a);
    return a == ADDR_CTRL || a == ADDR_START || a == ADDR_STATUS ||
           a == ADDR_CAPTURE || a == ADDR_LEVELS;
  endfunction : addr_ok

  function automatic logic edge_hit(input edge_e sel, input logic cur, input logic prev);
    case (sel)
      EDGE_RISE: return cur & ~prev;
      EDGE_FALL: return ~cur & prev;
      EDGE_BOTH: return cur ^ prev;
      default: return 1'b0;
    endcase
  endfunction : edge_hit

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // ----------------------------------------
  // Registers and bus
  // ----------------------------------------
  cfg_s cfg_q, cfg_d;
  logic [31:0] start_q, start_d, cap_q, cap_d, prdata_q, prdata_d;
  logic [ST_W-1:0] st_q, st_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic setup, wr_acc, rearm;
  logic sync_trig, cap_trig, ab_err, wb_now;
  logic [2:0] filt_q, filt_d, prev_q;

  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pready_q & pwrite & ~pslverr_q;
  assign rearm = wr_acc && paddr == ADDR_CTRL && pstrb[3] && pwdata[31];
  assign wb_now = cfg_q.push_pull & (|wb_fault); // R21

  always_comb begin
    pready_d = setup;
    pslverr_d = setup & ~addr_ok(paddr);
    prdata_d = prdata_q;
    if (setup && !pwrite) begin
      case (paddr)
        ADDR_CTRL: prdata_d = cfg_q & CTRL_RD_MASK;
        ADDR_START: prdata_d = start_q;
        ADDR_STATUS: prdata_d = {{(32-ST_W){1'b0}}, st_q};
        ADDR_CAPTURE: prdata_d = cap_q;
        ADDR_LEVELS: prdata_d = {29'h0, filt_q};
        default: prdata_d = 32'h0000_0000;
      endcase
    end
    cfg_d = cfg_q;
    start_d = start_q;
    if (wr_acc && paddr == ADDR_CTRL) begin
      cfg_d = merge(cfg_q, pwdata, pstrb) & CTRL_RD_MASK;
    end
    if (wr_acc && paddr == ADDR_START) begin
      start_d = merge(start_q, pwdata, pstrb);
    end
    // Write one to clear; a new event in the same cycle wins
    st_d = st_q;
    if (wr_acc && paddr == ADDR_STATUS && pstrb[0]) begin
      st_d[ST_AB_ERR:0] = st_q[ST_AB_ERR:0] & ~pwdata[ST_AB_ERR:0];
    end
    if (rearm) begin
      st_d[ST_CAP_DONE:ST_SYNC_DONE] = 2'b00;
    end
    if (sync_trig) begin
      st_d[ST_SYNC_EVT] = 1'b1;
      st_d[ST_SYNC_DONE] = 1'b1;
    end
    if (cap_trig) begin
      st_d[ST_CAP_EVT] = 1'b1;
      st_d[ST_CAP_DONE] = 1'b1;
    end
    if (wb_now) begin
      st_d[ST_WIRE_BRK] = 1'b1; // R21
    end
    if (ab_err) begin
      st_d[ST_AB_ERR] = 1'b1;
    end
    cap_d = cap_trig ? counter_value : cap_q; // R12
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= cfg_s'(CTRL_RST);
      start_q <= START_RST;
      st_q <= '0;
      cap_q <= '0;
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      start_q <= start_d;
      st_q <= st_d;
      cap_q <= cap_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ----------------------------------------
  // Glitch filters
  // ----------------------------------------
  // Any step code above the table falls back to the fastest filter
  filt_cnt_t thr;
  filt_cnt_t run_q [3];
  filt_cnt_t run_d [3];
  logic [2:0] raw;
  assign raw = {enc_n, enc_b, enc_a};
  assign thr = (cfg_q.filt_sel < 4'hD) ? FILT_CYC[cfg_q.filt_sel] : FILT_CYC[N_FILT-1]; // R07

  for (genvar gi = 0; gi < 3; gi++) begin : g_filt
    always_comb begin
      run_d[gi] = run_q[gi];
      filt_d[gi] = filt_q[gi];
      if (raw[gi] == filt_q[gi]) begin
        run_d[gi] = '0; // R06
      end else if (run_q[gi] >= thr - 1'b1) begin
        filt_d[gi] = raw[gi]; // R05
        run_d[gi] = '0;
      end else begin
        run_d[gi] = run_q[gi] + 1'b1;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        run_q[gi] <= '0;
        filt_q[gi] <= 1'b0;
      end else begin
        run_q[gi] <= run_d[gi];
        filt_q[gi] <= filt_d[gi];
      end
    end
  end

  // ----------------------------------------
  // Edge evaluation and zero pulse
  // ----------------------------------------
  logic a, b, n, ea, eb, quad_type, dir_up, n_rise;
  logic di_prev_q, cap_prev_q;
  logic di_sync_hit, di_cap_hit, sync_on, cap_n;
  logic up_d, dn_d, up_q, dn_q, load_q, strobe_q, wb_q;

  assign a = filt_q[0];
  assign b = filt_q[1];
  assign n = filt_q[2];
  assign ea = a ^ prev_q[0];
  assign eb = b ^ prev_q[1];
  assign n_rise = n & ~prev_q[2];
  assign quad_type = cfg_q.sig == SIG_AB || cfg_q.sig == SIG_ABN; // R04
  assign dir_up = (ea ? (a != b) : (a == b)) ^ cfg_q.invert; // R22 R23
  assign ab_err = quad_type & ea & eb;

  always_comb begin
    up_d = 1'b0;
    dn_d = 1'b0;
    case (cfg_q.sig)
      SIG_AB, SIG_ABN: begin
        if (!ab_err) begin
          case (cfg_q.eval)
            EVAL_DOUBLE: up_d = ea; // R02
            EVAL_QUAD: up_d = ea | eb; // R03
            default: up_d = ea & ~b; // R01
          endcase
          dn_d = up_d & ~dir_up;
          up_d = up_d & dir_up;
        end
      end
      SIG_PULSE_DIR: begin
        up_d = ea & a & ~b;
        dn_d = ea & a & b;
      end
      SIG_PULSE: begin
        up_d = ea & a & ~cfg_q.pulse_down;
        dn_d = ea & a & cfg_q.pulse_down;
      end
      SIG_UPDOWN: begin
        up_d = ea & a & ~(eb & b);
        dn_d = eb & b & ~(ea & a);
      end
      default: begin
        up_d = 1'b0;
        dn_d = 1'b0;
      end
    endcase
  end

  // One done flag and one frequency bit serve N and the input alike
  assign di_sync_hit = edge_hit(cfg_q.di_sync_edge, di_sync, di_prev_q);
  assign di_cap_hit = edge_hit(cfg_q.di_cap_edge, di_capture, cap_prev_q);
  assign sync_on = cfg_q.sig == SIG_ABN && cfg_q.nreact == NREACT_SYNC && n_rise &&
                   (!cfg_q.sync_di_gate || di_gate); // R09 R10 R11 R14
  assign cap_n = cfg_q.sig == SIG_ABN && cfg_q.nreact == NREACT_CAPTURE &&
                 cfg_q.count_ref && n_rise; // R14 R15
  assign sync_trig = (sync_on | di_sync_hit) &
                     (cfg_q.sync_periodic | ~st_q[ST_SYNC_DONE]); // R16 R17 R18
  assign cap_trig = (cap_n | di_cap_hit) &
                    (cfg_q.cap_periodic | ~st_q[ST_CAP_DONE]); // R13 R19 R20

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 3'b000;
      di_prev_q <= 1'b0;
      cap_prev_q <= 1'b0;
      up_q <= 1'b0;
      dn_q <= 1'b0;
      load_q <= 1'b0;
      strobe_q <= 1'b0;
      wb_q <= 1'b0;
    end else begin
      prev_q <= filt_q;
      di_prev_q <= di_sync;
      cap_prev_q <= di_capture;
      up_q <= up_d;
      dn_q <= dn_d;
      load_q <= sync_trig;
      strobe_q <= cap_trig;
      wb_q <= wb_now;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign cnt_up = up_q;
  assign cnt_down = dn_q;
  assign sync_load = load_q;
  assign start_value = start_q;
  assign cap_strobe = strobe_q;
  assign capture_value = cap_q;
  assign wire_break = wb_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Run of A samples that differ from the filtered level; a flip restarts it
  filt_cnt_t diff_run;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      diff_run <= '0;
    end else begin
      diff_run <= (raw[0] != filt_q[0] && filt_d[0] == filt_q[0]) ? diff_run + 1'b1 : '0;
    end
  end

  sequence sync_req_s;
    sync_on && cfg_q.sync_periodic;
  endsequence
  sequence load_s;
    sync_load && start_value == $past(start_q);
  endsequence
  // Both capture sources share one path, so either alone must land
  sequence cap_req_s;
    (cap_n || di_cap_hit) && (cfg_q.cap_periodic || !st_q[ST_CAP_DONE]);
  endsequence

  single_mode_a: assert property (quad_type && cfg_q.eval == EVAL_SINGLE && eb && !ea
    |=> !cnt_up && !cnt_down) else $error("single mode counted a B edge"); // R01
  double_mode_a: assert property (quad_type && cfg_q.eval == EVAL_DOUBLE && ea && !eb
    |=> cnt_up || cnt_down) else $error("double mode missed an A edge"); // R02
  quad_mode_a: assert property (quad_type && cfg_q.eval == EVAL_QUAD && (ea ^ eb)
    |=> cnt_up ^ cnt_down) else $error("quadruple mode missed an edge"); // R03
  eval_scope_a: assert property (cfg_q.sig == SIG_PULSE && ea && !a
    |=> !cnt_up && !cnt_down) else $error("pulse mode counted a falling edge"); // R04
  quad_dir_a: assert property (quad_type && cfg_q.eval == EVAL_QUAD && ea && !eb
    |=> cnt_up == (($past(a) != $past(b)) ^ $past(cfg_q.invert)))
    else $error("wrong direction"); // R22 R23
  filter_len_a: assert property ($changed(filt_q[0]) && $past(raw[0]) != $past(filt_q[0])
    |-> $past(diff_run) + 1'b1 >= $past(thr)) else $error("short pulse passed"); // R05 R06 R07
  no_react_a: assert property (cfg_q.nreact != NREACT_SYNC && !di_sync_hit
    |=> !sync_load) else $error("N loaded without sync reaction"); // R09 R14
  sync_n_a: assert property (sync_req_s |=> load_s)
    else $error("periodic N sync did not load"); // R10 R18
  gate_off_a: assert property (cfg_q.sync_di_gate && !di_gate && !di_sync_hit
    |=> !sync_load) else $error("N sync while gate inactive"); // R11
  sync_once_a: assert property (st_q[ST_SYNC_DONE] && !cfg_q.sync_periodic
    |=> !sync_load) else $error("once sync loaded twice"); // R17
  cap_both_a: assert property (cap_req_s |=> cap_strobe && capture_value == $past(counter_value))
    else $error("combined capture lost"); // R12 R13 R20
  cap_ref_a: assert property (!cfg_q.count_ref && !di_cap_hit |=> !cap_strobe)
    else $error("N capture outside reference mode"); // R15
  cap_once_a: assert property (st_q[ST_CAP_DONE] && !cfg_q.cap_periodic |=> !cap_strobe)
    else $error("once capture stored twice"); // R19
  wire_mon_a: assert property (cfg_q.push_pull && |wb_fault
    |=> wire_break ##0 st_q[ST_WIRE_BRK]) else $error("wire break not flagged"); // R21
  // A flag being set outweighs a clear written in the same cycle
  status_set_a: assert property (wr_acc && paddr == ADDR_STATUS && pstrb[0] && wb_now // R21
    |=> st_q[ST_WIRE_BRK]) else $error("wire break flag lost to a clear");
  di_sync_a: assert property (di_sync_hit && (cfg_q.sync_periodic || !st_q[ST_SYNC_DONE]) // R16
    |=> sync_load) else $error("input sync did not load");
  eval_ignore_a: assert property (cfg_q.sig == SIG_PULSE && eb && !ea // R04
    |=> !cnt_up && !cnt_down) else $error("pulse mode counted a B edge");

endmodule : incremental_encoder_frontend

`default_nettype wire

// >>> design/enc_frontend_pkg.sv
// Constants, field layouts and types for the encoder front end.
// Assumes a 20 MHz pclk and a 32-bit APB register bus.
package enc_frontend_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int N_FILT = 13;
  localparam int CNT_W = 17;
  typedef logic [CNT_W-1:0] filt_cnt_t;

  // Minimum pulse/break time per filter step, 100 Hz .. 1 MHz
  localparam longint FILT_MIN_NS [N_FILT] = '{
    4000000, 2000000, 800000, 400000, 200000, 80000, 40000,
    20000, 8000, 4000, 2000, 800, 400};

  // Least time, so round up
  function automatic filt_cnt_t ns_to_cyc(input longint ns);
    return filt_cnt_t'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  endfunction : ns_to_cyc

  localparam filt_cnt_t FILT_CYC_DEF [N_FILT] = '{
    ns_to_cyc(FILT_MIN_NS[0]), ns_to_cyc(FILT_MIN_NS[1]), ns_to_cyc(FILT_MIN_NS[2]),
    ns_to_cyc(FILT_MIN_NS[3]), ns_to_cyc(FILT_MIN_NS[4]), ns_to_cyc(FILT_MIN_NS[5]),
    ns_to_cyc(FILT_MIN_NS[6]), ns_to_cyc(FILT_MIN_NS[7]), ns_to_cyc(FILT_MIN_NS[8]),
    ns_to_cyc(FILT_MIN_NS[9]), ns_to_cyc(FILT_MIN_NS[10]), ns_to_cyc(FILT_MIN_NS[11]),
    ns_to_cyc(FILT_MIN_NS[12])};

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_START = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_CAPTURE = 8'h0C;
  localparam logic [7:0] ADDR_LEVELS = 8'h10;
  localparam logic [31:0] CTRL_RST = 32'h0000_1120;
  localparam logic [31:0] CTRL_RD_MASK = 32'h003F_FFFF;
  localparam logic [31:0] START_RST = 32'h0000_0000;
  localparam int ST_SYNC_EVT = 0;
  localparam int ST_CAP_EVT = 1;
  localparam int ST_WIRE_BRK = 2;
  localparam int ST_AB_ERR = 3;
  localparam int ST_SYNC_DONE = 4;
  localparam int ST_CAP_DONE = 5;
  localparam int ST_W = 6;

  // ----------------------------------------
  // Modes
  // ----------------------------------------
  typedef enum logic [2:0] {SIG_AB, SIG_ABN, SIG_PULSE_DIR, SIG_PULSE, SIG_UPDOWN} sig_e;
  typedef enum logic [1:0] {EVAL_SINGLE, EVAL_DOUBLE, EVAL_QUAD} eval_e;
  typedef enum logic [1:0] {NREACT_NONE, NREACT_SYNC, NREACT_CAPTURE} nreact_e;
  typedef enum logic [1:0] {EDGE_OFF, EDGE_RISE, EDGE_FALL, EDGE_BOTH} edge_e;

  typedef struct packed {
    logic rearm;
    logic [8:0] rsvd;
    logic pulse_down;
    edge_e di_cap_edge;
    edge_e di_sync_edge;
    logic sync_di_gate;
    logic count_ref;
    logic push_pull;
    logic invert;
    logic cap_periodic;
    logic sync_periodic;
    nreact_e nreact;
    logic [3:0] filt_sel;
    eval_e eval;
    sig_e sig;
  } cfg_s;

endpackage : enc_frontend_pkg

// >>> testbench/encoder_model.sv
// Behavioural incremental encoder: A and B in quadrature plus zero pulse N.
// Assumes the bench calls its tasks just after a rising pclk edge.
`timescale 1ns/1ps
`default_nettype none

module encoder_model (
  input wire logic pclk, // Sample clock
  output logic enc_a, // Phase A
  output logic enc_b, // Phase B
  output logic enc_n // Zero pulse
);
  // Each level is held well past any filter time, so duty stays near 50:50
  int hold = 10;

  initial begin
    enc_a = 1'b0;
    enc_b = 1'b0;
    enc_n = 1'b0;
  end

  // Quarter steps; up means A leads B
  task automatic step(input bit up, input int n);
    for (int i = 0; i < n; i++) begin
      if ((enc_a == enc_b) == up)
        enc_a <= ~enc_a;
      else
        enc_b <= ~enc_b;
      repeat (hold) @(posedge pclk);
    end
  endtask : step

  // A short len gives a glitch the filter must drop
  task automatic zero(input int len);
    enc_n <= 1'b1;
    repeat (len) @(posedge pclk);
    enc_n <= 1'b0;
    repeat (hold) @(posedge pclk);
  endtask : zero
endmodule : encoder_model
`default_nettype wire

// >>> testbench/tb_top.sv
// Self-checking bench for the encoder front end.
// Assumes all filter steps shortened to 4 cycles and an ideal encoder model.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, exp, got) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      num_errors++; \
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); \
    end \
  end

module tb_top
  import enc_frontend_pkg::*;
();
  // ----------------------------------------
  // Harness
  // ----------------------------------------
  localparam filt_cnt_t SIM_CYC [N_FILT] = '{default: 17'h4};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, counter_value, start_value, capture_value, rd;
  logic [3:0] pstrb;
  logic enc_a, enc_b, enc_n, di_sync, di_gate, di_capture, err;
  logic [2:0] wb_fault;
  logic cnt_up, cnt_down, sync_load, cap_strobe, wire_break;
  int num_errors = 0;
  int tests_run = 0;
  int n_up = 0;
  int n_dn = 0;
  int n_sy = 0;
  int n_cp = 0;
  int b;

  incremental_encoder_frontend #(.FILT_CYC(SIM_CYC)) incremental_encoder_frontend_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .enc_a(enc_a), .enc_b(enc_b), .enc_n(enc_n), .wb_fault(wb_fault),
    .di_sync(di_sync), .di_gate(di_gate), .di_capture(di_capture),
    .counter_value(counter_value), .cnt_up(cnt_up), .cnt_down(cnt_down),
    .sync_load(sync_load), .start_value(start_value), .cap_strobe(cap_strobe),
    .capture_value(capture_value), .wire_break(wire_break));

  encoder_model encoder_model_inst (
    .pclk(pclk), .enc_a(enc_a), .enc_b(enc_b), .enc_n(enc_n));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // One-cycle pulses are tallied on the edge that samples them
  always @(posedge pclk) begin
    if (cnt_up === 1'b1) n_up++;
    if (cnt_down === 1'b1) n_dn++;
    if (sync_load === 1'b1) n_sy++;
    if (cap_strobe === 1'b1) n_cp++;
  end

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask : idle

  task automatic sync_pulse();
    di_sync <= 1'b1;
    idle(4);
    di_sync <= 1'b0;
    idle(4);
  endtask : sync_pulse

  task automatic apb(input bit wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      num_errors++;
      test_done();
    end
    @(posedge pclk);
  endtask : apb

  task automatic cfg(input sig_e s, input eval_e e, input nreact_e r, input bit per,
                     input bit inv, input bit cref, input bit gate, input bit pp);
    cfg_s c;
    c = '0;
    c.sig = s;
    c.eval = e;
    c.filt_sel = 4'h9;
    c.nreact = r;
    c.sync_periodic = per;
    c.cap_periodic = per;
    c.invert = inv;
    c.count_ref = cref;
    c.sync_di_gate = gate;
    c.push_pull = pp;
    c.di_cap_edge = EDGE_RISE;
    c.di_sync_edge = EDGE_RISE;
    c.rearm = 1'b1;
    apb(1'b1, ADDR_CTRL, 32'(c));
  endtask : cfg

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    apb(1'b0, ADDR_CTRL, 32'h0);
    `CHK("ctrl reset", CTRL_RST, rd)
    apb(1'b1, ADDR_START, 32'hA5A5_0F0F);
    apb(1'b0, ADDR_START, 32'h0);
    `CHK("start readback", 32'hA5A5_0F0F, rd)
    `CHK("start port", 32'hA5A5_0F0F, start_value)
    pstrb <= 4'h1;
    apb(1'b1, ADDR_START, 32'h1122_3344);
    pstrb <= 4'hF;
    apb(1'b0, ADDR_START, 32'h0);
    `CHK("start byte lane", 32'hA5A5_0F44, rd)
    apb(1'b0, 8'h3C, 32'h0);
    `CHK("unmapped error", 1'b1, err)
    $display("test regs finished");
  endtask : t_regs

  task automatic t_eval();
    eval_e ev [3] = '{EVAL_SINGLE, EVAL_DOUBLE, EVAL_QUAD};
    int exp_n [3] = '{1, 2, 4};
    sig_e pm [3] = '{SIG_PULSE, SIG_PULSE_DIR, SIG_UPDOWN};
    int exp_d [3] = '{0, 0, 1};
    int bd;
    for (int i = 0; i < 3; i++) begin
      cfg(SIG_AB, ev[i], NREACT_NONE, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      b = n_up;
      encoder_model_inst.step(1'b1, 4);
      idle(8);
      `CHK("edges counted up", exp_n[i], n_up - b)
    end
    b = n_dn;
    encoder_model_inst.step(1'b0, 4);
    idle(8);
    `CHK("edges counted down", 4, n_dn - b)
    cfg(SIG_ABN, EVAL_QUAD, NREACT_NONE, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    b = n_dn;
    encoder_model_inst.step(1'b1, 4);
    idle(8);
    `CHK("inverted direction", 4, n_dn - b)
    for (int i = 0; i < 3; i++) begin
      cfg(pm[i], EVAL_QUAD, NREACT_NONE, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      b = n_up;
      bd = n_dn;
      encoder_model_inst.step(1'b1, 4);
      idle(8);
      `CHK("other type up", 1, n_up - b)
      `CHK("other type down", exp_d[i], n_dn - bd)
    end
    $display("test eval finished");
  endtask : t_eval

  task automatic t_sync();
    cfg(SIG_ABN, EVAL_SINGLE, NREACT_SYNC, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    b = n_sy;
    encoder_model_inst.zero(6);
    encoder_model_inst.zero(6);
    sync_pulse();
    `CHK("sync once", 1, n_sy - b)
    cfg(SIG_ABN, EVAL_SINGLE, NREACT_SYNC, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    b = n_sy;
    encoder_model_inst.zero(6);
    `CHK("sync gated off", 0, n_sy - b)
    di_gate <= 1'b1;
    encoder_model_inst.zero(6);
    encoder_model_inst.zero(6);
    `CHK("sync periodic", 2, n_sy - b)
    sync_pulse();
    `CHK("input sync periodic", 3, n_sy - b)
    cfg(SIG_AB, EVAL_SINGLE, NREACT_SYNC, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    b = n_sy;
    encoder_model_inst.zero(6);
    `CHK("sync needs ABN", 0, n_sy - b)
    cfg(SIG_ABN, EVAL_SINGLE, NREACT_NONE, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    b = n_sy + n_cp;
    encoder_model_inst.zero(6);
    `CHK("no reaction", 0, n_sy + n_cp - b)
    $display("test sync finished");
  endtask : t_sync

  task automatic t_cap();
    counter_value <= 32'h1234_ABCD;
    cfg(SIG_ABN, EVAL_SINGLE, NREACT_CAPTURE, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    b = n_cp;
    encoder_model_inst.zero(2);
    `CHK("glitch dropped", 0, n_cp - b)
    encoder_model_inst.zero(6);
    counter_value <= 32'h0F0F_7777;
    di_capture <= 1'b1;
    idle(4);
    di_capture <= 1'b0;
    `CHK("input capture value", 32'h0F0F_7777, capture_value)
    counter_value <= 32'h5A5A_C3C3;
    encoder_model_inst.zero(6);
    `CHK("capture periodic", 3, n_cp - b)
    `CHK("capture value", 32'h5A5A_C3C3, capture_value)
    apb(1'b0, ADDR_CAPTURE, 32'h0);
    `CHK("capture register", 32'h5A5A_C3C3, rd)
    cfg(SIG_ABN, EVAL_SINGLE, NREACT_CAPTURE, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    b = n_cp;
    encoder_model_inst.zero(6);
    `CHK("capture needs count_ref", 0, n_cp - b)
    cfg(SIG_ABN, EVAL_SINGLE, NREACT_CAPTURE, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    b = n_cp;
    encoder_model_inst.zero(6);
    encoder_model_inst.zero(6);
    `CHK("capture once", 1, n_cp - b)
    $display("test capture finished");
  endtask : t_cap

  task automatic t_wb();
    cfg(SIG_AB, EVAL_SINGLE, NREACT_NONE, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    wb_fault <= 3'h2;
    idle(3);
    `CHK("wire break seen", 1'b1, wire_break)
    apb(1'b1, ADDR_STATUS, 32'h0000_000F);
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK("break flag survives clear", 32'h0000_0004, rd)
    wb_fault <= 3'h0;
    idle(3);
    `CHK("wire break cleared", 1'b0, wire_break)
    apb(1'b1, ADDR_STATUS, 32'h0000_000F);
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK("status cleared", 32'h0, rd)
    $display("test wire break finished");
  endtask : t_wb

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    wb_fault = 3'h0;
    di_sync = 1'b0;
    di_gate = 1'b0;
    di_capture = 1'b0;
    counter_value = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_eval();
    t_sync();
    t_cap();
    t_wb();
    test_done();
  end
endmodule : tb_top
`default_nettype wire
